//--- src/adcio_pkg.sv
// shared constants for the quad converter serial i/o block
// assumes a 250 MHz system clock; pins arrive asynchronous
package adcio_pkg;
	localparam int CH_N = 4;
	localparam int RES_W = 16;
	localparam int CODE_W = 3;
	localparam int CFG_W = CH_N * CODE_W;
	localparam int CHID_W = 2;
	localparam int PAD_W = 3;
	localparam int WORD_W = RES_W + CHID_W + CODE_W + PAD_W;
	localparam int FRAME_W = CH_N * WORD_W;
	localparam int CNT_W = 16;
	localparam int CLK_NS = 4;
	localparam int CONV_TIME_NS = 500;
	// least time, so round up
	localparam int CONV_CYC = (CONV_TIME_NS + CLK_NS - 1) / CLK_NS;
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFS_CONV = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_CONFIG = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_SAMPLE0 = 8'h10;
	localparam logic [CFG_W-1:0] CFG_RST = 12'hfff;
	localparam logic [CODE_W-1:0] CODE_OFF = 3'h0;
	localparam int CODE_BIPOLAR_BIT = 1;
	localparam int ST_BUSY = 0;
	localparam int ST_PWR_DN = 1;
	localparam int ST_LVDS = 2;
	localparam int ST_CFG_LSB = 16;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
	localparam logic [2:0] SEL_CONV = 3'h0;
	localparam logic [2:0] SEL_STATUS = 3'h1;
	localparam logic [2:0] SEL_CONFIG = 3'h2;
	localparam logic [2:0] SEL_SAMPLE = 3'h3;
	localparam logic [2:0] SEL_NONE = 3'h7;
	typedef enum logic [2:0] {
		ADCIO_IDLE = 3'b001,
		ADCIO_CONV = 3'b010,
		ADCIO_DONE = 3'b100
	} adcio_state_e;
endpackage : adcio_pkg

//--- src/adcio_sync.sv
// two flip-flop level synchroniser
// assumes inputs are asynchronous to aclk
`timescale 1ns/1ps
module adcio_sync #(
	parameter int W = 1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule : adcio_sync

//--- src/adcio_conv.sv
// conversion engine: freezes samples and range codes, times the conversion
// assumes start is a one-cycle pulse only issued while idle
`timescale 1ns/1ps
module adcio_conv (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clr,
	input wire logic start,
	input wire logic [adcio_pkg::CNT_W-1:0] conv_cycles,
	input wire logic [adcio_pkg::CH_N*adcio_pkg::RES_W-1:0] samples,
	input wire logic [adcio_pkg::CFG_W-1:0] codes,
	output logic busy,
	output logic [adcio_pkg::CH_N*adcio_pkg::RES_W-1:0] results,
	output logic [adcio_pkg::CFG_W-1:0] codes_used
);
	localparam int RW = adcio_pkg::RES_W;
	localparam int CW = adcio_pkg::CODE_W;
	adcio_pkg::adcio_state_e state_q;
	adcio_pkg::adcio_state_e state_d;
	logic [adcio_pkg::CNT_W-1:0] cnt_q;
	logic [adcio_pkg::CH_N*RW-1:0] samp_q;
	logic [adcio_pkg::CH_N*RW-1:0] res_d;
	wire cnt_end = (cnt_q <= 16'h0001);

	function automatic logic [RW-1:0] fmt(input logic [RW-1:0] s, input logic [CW-1:0] c);
		logic [RW-1:0] r;
		r = '0;
		if (c == adcio_pkg::CODE_OFF)
			r = '0;
		else if (c[adcio_pkg::CODE_BIPOLAR_BIT])
			r = s;
		else if (!s[RW-1])
			r = {s[RW-2:0], 1'b0};
		return r;
	endfunction : fmt

	for (genvar i = 0; i < adcio_pkg::CH_N; i++) begin : g_ch
		assign res_d[i*RW +: RW] = fmt(samp_q[i*RW +: RW], codes_used[i*CW +: CW]);
	end

	always_comb begin
		state_d = state_q;
		case (state_q)
			adcio_pkg::ADCIO_IDLE: if (start) state_d = adcio_pkg::ADCIO_CONV;
			adcio_pkg::ADCIO_CONV: if (cnt_end) state_d = adcio_pkg::ADCIO_DONE;
			adcio_pkg::ADCIO_DONE: state_d = adcio_pkg::ADCIO_IDLE;
			default: state_d = adcio_pkg::ADCIO_IDLE;
		endcase
	end

	assign busy = (state_q != adcio_pkg::ADCIO_IDLE);

	always_ff @(posedge aclk) begin
		if (!aresetn || clr) begin
			state_q <= adcio_pkg::ADCIO_IDLE;
			cnt_q <= '0;
			samp_q <= '0;
			codes_used <= adcio_pkg::CFG_RST;
			results <= '0;
		end else begin
			state_q <= state_d;
			if (start && state_q == adcio_pkg::ADCIO_IDLE) begin
				samp_q <= samples;
				codes_used <= codes;
				cnt_q <= conv_cycles;
			end else if (cnt_q != '0) begin
				cnt_q <= cnt_q - 16'h0001;
			end
			if (state_q == adcio_pkg::ADCIO_DONE)
				results <= res_d;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn || clr);

	a_start_busy: assert property (start |=> busy)
		else $error("busy did not rise after start");
	a_off_zero: assert property (state_q == adcio_pkg::ADCIO_DONE &&
		codes_used[CW-1:0] == adcio_pkg::CODE_OFF |=> results[RW-1:0] == '0)
		else $error("disabled channel not zero");
	a_bip_pass: assert property (state_q == adcio_pkg::ADCIO_DONE &&
		codes_used[adcio_pkg::CODE_BIPOLAR_BIT] |=> results[RW-1:0] == $past(samp_q[RW-1:0]))
		else $error("bipolar result altered");
	c_conv_done: cover property (start ##[1:300] !busy);
endmodule : adcio_conv

//--- src/adcio_top.sv
// serial i/o and range configuration of a quad simultaneous-sampling converter
// assumes async pins synchronised here; axi4-lite master on aclk
`timescale 1ns/1ps
module adcio_top #(
	parameter logic [adcio_pkg::CNT_W-1:0] CONV_CYCLES = adcio_pkg::CONV_CYC[adcio_pkg::CNT_W-1:0]
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [adcio_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [adcio_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic shift_clock_in,
	input wire logic cs_n_in,
	input wire logic config_serial_in,
	input wire logic convert_strobe,
	input wire logic power_down_in,
	input wire logic lvds_mode_in,
	output logic [adcio_pkg::CH_N-1:0] result_lane_out,
	output logic [adcio_pkg::CH_N-1:0] result_lane_oe,
	output logic result_lane_lvds_out,
	output logic result_lane_lvds_oe,
	output logic echo_clock_out,
	output logic echo_clock_oe,
	output logic config_pos_term_en,
	output logic busy_out
);
	localparam int CH = adcio_pkg::CH_N;
	localparam int WW = adcio_pkg::WORD_W;
	localparam int FW = adcio_pkg::FRAME_W;
	localparam int RW = adcio_pkg::RES_W;
	localparam int CW = adcio_pkg::CODE_W;
	localparam int NCFG = adcio_pkg::CFG_W;

	logic sck_s, cs_sel_s, cfg_bit_s, strobe_s, pwr_dn_s, lvds_s;
	logic sck_d_q, cs_act_q, strobe_d_q, pwr_dn_d_q, busy_d_q;
	logic [FW-1:0] frame_q, frame_d, frame_load, frame_cmos;
	logic [NCFG-1:0] cfg_sh_q, cfg_q;
	logic [3:0] cfg_cnt_q;
	logic echo_q, pwr_dn_armed_q;
	logic [adcio_pkg::CNT_W-1:0] conv_cyc_q;
	logic [RW-1:0] samp_q [CH];
	logic [CH*RW-1:0] samp_flat, results;
	logic [NCFG-1:0] codes_used;
	logic conv_busy;

	// select enters inverted: a synchroniser held in reset then reads as deselected,
	// so no false select edge and no enabled outputs around reset
	adcio_sync #(.W(6)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d({shift_clock_in, ~cs_n_in, config_serial_in, convert_strobe, power_down_in,
			lvds_mode_in}),
		.q({sck_s, cs_sel_s, cfg_bit_s, strobe_s, pwr_dn_s, lvds_s})
	);

	wire sck_rise = sck_s & ~sck_d_q;
	wire sck_fall = ~sck_s & sck_d_q;
	wire cs_act = cs_sel_s;
	wire cs_fall = cs_act & ~cs_act_q;
	wire cs_rise = ~cs_act & cs_act_q;
	wire busy_fall = ~conv_busy & busy_d_q;
	wire strobe_rise = strobe_s & ~strobe_d_q;
	wire pwr_dn_rise = pwr_dn_s & ~pwr_dn_d_q;
	wire lvds_edge = lvds_s & (sck_rise | sck_fall);
	wire cmos_adv = ~lvds_s & cs_act & sck_rise;
	wire lvds_adv = cs_act & lvds_edge;
	wire frame_ld = cs_fall | (busy_fall & cs_act);
	wire cfg_full = (cfg_cnt_q >= 4'(NCFG));
	wire conv_start = strobe_rise & ~pwr_dn_s & ~conv_busy;
	wire soft_rst = pwr_dn_rise & pwr_dn_armed_q;

	for (genvar i = 0; i < CH; i++) begin : g_ch
		localparam int HI = (CH - i) * WW;
		assign samp_flat[i*RW +: RW] = samp_q[i];
		assign frame_load[HI-1 -: WW] = {results[i*RW +: RW], 2'(i),
			codes_used[i*CW +: CW], {adcio_pkg::PAD_W{1'b0}}};
		// each lane shifts its own word
		assign frame_cmos[HI-1 -: WW] = {frame_q[HI-2 -: WW-1], 1'b0};
		assign result_lane_out[i] = frame_q[HI-1];
	end

	assign frame_d = frame_ld ? frame_load :
		lvds_adv ? {frame_q[FW-2:0], 1'b0} :
		cmos_adv ? frame_cmos : frame_q;

	adcio_conv u_conv (
		.aclk(aclk),
		.aresetn(aresetn),
		.clr(soft_rst),
		.start(conv_start),
		.conv_cycles(conv_cyc_q),
		.samples(samp_flat),
		.codes(cfg_q),
		.busy(conv_busy),
		.results(results),
		.codes_used(codes_used)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{sck_d_q, cs_act_q, strobe_d_q, pwr_dn_d_q, busy_d_q} <= '0;
			frame_q <= '0;
		end else begin
			{sck_d_q, cs_act_q, strobe_d_q, pwr_dn_d_q, busy_d_q} <=
				{sck_s, cs_act, strobe_s, pwr_dn_s, conv_busy};
			frame_q <= frame_d;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || soft_rst) begin
			cfg_sh_q <= '0;
			cfg_cnt_q <= '0;
			cfg_q <= adcio_pkg::CFG_RST;
		end else begin
			if (cs_fall)
				cfg_cnt_q <= '0;
			else if (cmos_adv || lvds_adv) begin
				cfg_sh_q <= {cfg_sh_q[NCFG-2:0], cfg_bit_s};
				if (!cfg_full)
					cfg_cnt_q <= cfg_cnt_q + 4'h1;
			end
			if (cs_rise && cfg_full)
				cfg_q <= cfg_sh_q;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			echo_q <= 1'b0;
			pwr_dn_armed_q <= 1'b0;
		end else begin
			if (busy_fall && !lvds_s)
				echo_q <= 1'b0;
			else if (lvds_s)
				echo_q <= sck_s;
			else if (cmos_adv)
				echo_q <= ~echo_q;
			if (conv_start || soft_rst)
				pwr_dn_armed_q <= 1'b0;
			else if (pwr_dn_rise)
				pwr_dn_armed_q <= 1'b1;
		end
	end

	assign result_lane_oe = {CH{cs_act & ~lvds_s}};
	assign result_lane_lvds_oe = cs_act & lvds_s;
	assign echo_clock_oe = cs_act;
	assign result_lane_lvds_out = frame_q[FW-1];
	assign echo_clock_out = echo_q;
	assign config_pos_term_en = cs_act & lvds_s;
	assign busy_out = conv_busy;

	// register bus
	function automatic logic [2:0] reg_sel(input logic [adcio_pkg::ADDR_W-1:0] a);
		logic [2:0] s;
		s = adcio_pkg::SEL_NONE;
		if (a == adcio_pkg::OFS_CONV) s = adcio_pkg::SEL_CONV;
		else if (a == adcio_pkg::OFS_STATUS) s = adcio_pkg::SEL_STATUS;
		else if (a == adcio_pkg::OFS_CONFIG) s = adcio_pkg::SEL_CONFIG;
		else if (a >= adcio_pkg::OFS_SAMPLE0 && a < adcio_pkg::OFS_SAMPLE0 + 8'(CH * 4)
			&& a[1:0] == 2'h0) s = adcio_pkg::SEL_SAMPLE;
		return s;
	endfunction : reg_sel

	function automatic logic [15:0] strb16(input logic [15:0] o, input logic [31:0] d,
		input logic [3:0] s);
		return {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
	endfunction : strb16

	logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
	logic [adcio_pkg::ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q, rdata_q;
	logic [3:0] wstrb_q;
	logic [1:0] bresp_q, rresp_q;
	wire do_write = aw_hold_q & w_hold_q & ~bvalid_q;
	wire [2:0] wsel = reg_sel(awaddr_q);
	wire [2:0] rsel = reg_sel(s_axi_araddr);
	wire [1:0] widx = 2'(awaddr_q - adcio_pkg::OFS_SAMPLE0 >> 2);
	wire [1:0] ridx = 2'(s_axi_araddr - adcio_pkg::OFS_SAMPLE0 >> 2);
	wire [31:0] status_w = (32'(cfg_q) << adcio_pkg::ST_CFG_LSB) |
		(32'(lvds_s) << adcio_pkg::ST_LVDS) | (32'(pwr_dn_s) << adcio_pkg::ST_PWR_DN) |
		(32'(conv_busy) << adcio_pkg::ST_BUSY);
	wire [31:0] rmux = (rsel == adcio_pkg::SEL_CONV) ? 32'(conv_cyc_q) :
		(rsel == adcio_pkg::SEL_STATUS) ? status_w :
		(rsel == adcio_pkg::SEL_CONFIG) ? 32'(cfg_q) :
		(rsel == adcio_pkg::SEL_SAMPLE) ? 32'(samp_q[ridx]) : 32'h0000_0000;

	assign s_axi_awready = ~aw_hold_q;
	assign s_axi_wready = ~w_hold_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = ~rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{aw_hold_q, w_hold_q, bvalid_q, rvalid_q} <= '0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			{bresp_q, rresp_q} <= '0;
			rdata_q <= '0;
			conv_cyc_q <= CONV_CYCLES;
			for (int i = 0; i < CH; i++) samp_q[i] <= '0;
		end else begin
			if (s_axi_awvalid && !aw_hold_q) begin
				aw_hold_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_hold_q) begin
				w_hold_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (do_write) begin
				bvalid_q <= 1'b1;
				bresp_q <= (wsel == adcio_pkg::SEL_NONE) ? adcio_pkg::RESP_ERR : adcio_pkg::RESP_OK;
				if (wsel == adcio_pkg::SEL_CONV)
					conv_cyc_q <= strb16(conv_cyc_q, wdata_q, wstrb_q);
				if (wsel == adcio_pkg::SEL_SAMPLE)
					samp_q[widx] <= strb16(samp_q[widx], wdata_q, wstrb_q);
			end
			if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
			end
			if (s_axi_arvalid && !rvalid_q) begin
				rvalid_q <= 1'b1;
				rdata_q <= rmux;
				rresp_q <= (rsel == adcio_pkg::SEL_NONE) ? adcio_pkg::RESP_ERR : adcio_pkg::RESP_OK;
			end else if (rvalid_q && s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_oe_select: assert property ((!cs_n_in)[*4] |-> echo_clock_oe)
		else $error("outputs not enabled while selected");
	a_idle_frozen: assert property (!cs_act |=> $stable(frame_q))
		else $error("frame moved while deselected");
	a_echo_toggle: assert property (cmos_adv && !busy_fall |=> echo_q != $past(echo_q))
		else $error("echo clock did not toggle");
	a_echo_low: assert property (busy_fall && !lvds_s |=> !echo_clock_out)
		else $error("echo clock not forced low");
	a_echo_copy: assert property (lvds_s |=> echo_clock_out == $past(sck_s))
		else $error("lvds echo not a copy");
	a_lvds_shift: assert property (lvds_adv && !frame_ld |=>
		frame_q == {$past(frame_q[FW-2:0]), 1'b0})
		else $error("lvds lane did not advance");
	a_cfg_sample: assert property ((cmos_adv || lvds_adv) && !cs_fall |=>
		cfg_sh_q[0] == $past(cfg_bit_s))
		else $error("config bit not sampled");
	a_cfg_latch: assert property (cs_rise && cfg_full && !soft_rst |=>
		cfg_q == $past(cfg_sh_q))
		else $error("config word not latched");
	a_pwr_block: assert property (pwr_dn_s && strobe_rise && !conv_busy |=> !conv_busy)
		else $error("convert accepted in power down");
	a_start_any: assert property (strobe_rise && !pwr_dn_s && !conv_busy |=> conv_busy)
		else $error("convert strobe not honoured");
	c_frame: cover property (cs_fall ##[1:400] cs_rise && cfg_full);
	c_lvds: cover property (lvds_adv && sck_fall);
	c_reset: cover property (soft_rst);
endmodule : adcio_top

//--- verif/adcio_host.sv
// host serial receiver model: drives shift clock, select and config input
// assumes the link pins of adcio_top; captures lanes and echo clock per bit
`timescale 1ns/1ps
module adcio_host (
	output logic shift_clock_in,
	output logic cs_n_in,
	output logic config_serial_in,
	input wire logic [adcio_pkg::CH_N-1:0] result_lane_out,
	input wire logic result_lane_lvds_out,
	input wire logic echo_clock_out
);
	logic [23:0] lane_cap [4];
	logic [95:0] lvds_cap;
	logic [95:0] echo_cap;
	initial begin
		shift_clock_in = 1'b0;
		cs_n_in = 1'b1;
		config_serial_in = 1'b1;
	end
	// every task steps 1 ns off the caller's aclk edge so pin changes never race
	// the synchroniser flops
	task automatic select();
		#1;
		cs_n_in = 1'b0;
		#60;
	endtask : select
	// edges with select high; config driven low so a leak would show
	task automatic ghost(input int n);
		#1;
		config_serial_in = 1'b0;
		repeat (n) begin
			#16 shift_clock_in = 1'b1;
			#16 shift_clock_in = 1'b0;
		end
		config_serial_in = 1'b1;
	endtask : ghost
	task automatic transfer(input logic [95:0] bits, input int n, input logic lvds,
		input logic idle_hi);
		int i;
		#1;
		shift_clock_in = idle_hi;
		#20;
		cs_n_in = 1'b0;
		#60;
		for (i = 0; i < n; i++) begin
			config_serial_in = bits[n-1-i];
			if (!lvds) begin
				shift_clock_in = 1'b0;
			end
			#16;
			lvds_cap[95-i] = result_lane_lvds_out;
			echo_cap[95-i] = echo_clock_out;
			for (int c = 0; c < 4; c++) begin
				if (i < 24) begin
					lane_cap[c][23-i] = result_lane_out[c];
				end
			end
			shift_clock_in = lvds ? ~shift_clock_in : 1'b1;
			#16;
		end
		shift_clock_in = lvds ? 1'b0 : idle_hi;
		#16;
		cs_n_in = 1'b1;
		#60;
	endtask : transfer
endmodule : adcio_host

//--- verif/quad_adc_serial_io_config_bench.sv
// self-checking bench: axi4-lite register tasks plus host serial transfers
// assumes adcio_top with a short conversion time and the adcio_host model
`timescale 1ns/1ps
module quad_adc_serial_io_config_bench;
	localparam logic [11:0] CFG1 = 12'hfac;
	localparam logic [11:0] CFG2 = 12'h688;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic convert_strobe, power_down_in, lvds_mode_in;
	logic sck, csn, cfg_bit, lvds_out, lvds_oe, echo, echo_oe, term_en, busy_out;
	logic [3:0] lane, lane_oe;
	logic [15:0] smp [4] = '{16'h8001, 16'h1234, 16'hfff0, 16'h4321};
	int n_mismatch = 0;
	int comparisons = 0;
	int cyc = 0;
	adcio_top #(.CONV_CYCLES(16'h0008)) u_dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .shift_clock_in(sck),
		.cs_n_in(csn), .config_serial_in(cfg_bit), .convert_strobe(convert_strobe),
		.power_down_in(power_down_in), .lvds_mode_in(lvds_mode_in), .result_lane_out(lane),
		.result_lane_oe(lane_oe), .result_lane_lvds_out(lvds_out),
		.result_lane_lvds_oe(lvds_oe), .echo_clock_out(echo), .echo_clock_oe(echo_oe),
		.config_pos_term_en(term_en), .busy_out(busy_out));
	adcio_host u_host (.shift_clock_in(sck), .cs_n_in(csn), .config_serial_in(cfg_bit),
		.result_lane_out(lane), .result_lane_lvds_out(lvds_out), .echo_clock_out(echo));
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	task automatic conclude();
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : conclude
	// hang guard, far above the few thousand cycles the tests need
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			conclude();
		end
	end
	task automatic chk(input string what, input logic [95:0] exp, input logic [95:0] got);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (!aw_ok && s_axi_awready === 1'b1) begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_ok && s_axi_wready === 1'b1) begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk("bresp", er, s_axi_bresp);
	endtask : axi_write
	task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [31:0] m,
		input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk("rdata", ed, s_axi_rdata & m);
		chk("rresp", er, s_axi_rresp);
	endtask : axi_read
	// fixed window: busy must start and end well inside it
	task automatic convert(input int n_exp);
		int n;
		n = 0;
		convert_strobe <= 1'b1;
		repeat (40) begin
			@(posedge aclk);
			if (busy_out === 1'b1) n++;
		end
		convert_strobe <= 1'b0;
		repeat (4) @(posedge aclk);
		chk("busy_cycles", n_exp, n);
	endtask : convert
	function automatic logic [23:0] word(input int c, input logic [15:0] s, input logic [2:0] k);
		logic [15:0] r;
		r = (k == 3'h0) ? 16'h0 : k[1] ? s : s[15] ? 16'h0 : {s[14:0], 1'b0};
		return {r, c[1:0], k, 3'h0};
	endfunction : word
	task automatic chk_lanes(input logic [11:0] k);
		for (int c = 0; c < 4; c++) begin
			chk("lane_word", word(c, smp[c], k[3*c+:3]), u_host.lane_cap[c]);
		end
	endtask : chk_lanes
	initial begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		s_axi_awaddr = 8'h0;
		s_axi_araddr = 8'h0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		{convert_strobe, power_down_in, lvds_mode_in} = 3'h0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int c = 0; c < 4; c++) axi_write(8'h10 + 8'(4 * c), {16'h0, smp[c]}, 2'h0);
		axi_read(8'h00, 32'h8, '1, 2'h0);
		axi_read(8'h08, 32'hfff, '1, 2'h0); // reset word
		axi_read(8'h40, 32'h0, '1, 2'h2);
		axi_write(8'h44, 32'h1, 2'h2);
		u_host.ghost(13); // odd count would leave a leaked echo high
		chk("echo_idle", 1'b0, echo); // echo untouched
		axi_read(8'h08, 32'hfff, '1, 2'h0); // edges ignored
		// odd count leaves the echo clock high before the conversion
		u_host.transfer({84'h0, CFG1}, 13, 1'b0, 1'b0); // word sent
		axi_read(8'h08, {20'h0, CFG1}, '1, 2'h0); // word latched
		chk("oe_idle", 7'h0, {lane_oe, lvds_oe, echo_oe, term_en}); // released
		convert(9); // busy length
		u_host.transfer({72'h0, 12'h0, CFG2}, 24, 1'b0, 1'b1); // idle high
		chk_lanes(CFG1); // lane words
		chk("echo", 24'h555555, u_host.echo_cap[95:72]); // echo pattern
		axi_read(8'h08, {20'h0, CFG2}, '1, 2'h0); // new word
		convert(9); // new word applies
		u_host.transfer({72'h0, 12'h0, CFG2}, 24, 1'b0, 1'b0); // word kept
		chk_lanes(CFG2); // disabled and unipolar codes
		power_down_in <= 1'b1;
		convert(0); // convert refused
		axi_read(8'h04, 32'h2, 32'h3, 2'h0); // status seen
		power_down_in <= 1'b0;
		repeat (8) @(posedge aclk);
		power_down_in <= 1'b1;
		repeat (8) @(posedge aclk);
		axi_read(8'h08, 32'hfff, '1, 2'h0); // second rise resets
		power_down_in <= 1'b0;
		repeat (8) @(posedge aclk);
		u_host.select();
		chk("oe_cmos", 7'h7a, {lane_oe, lvds_oe, echo_oe, term_en}); // enables
		convert(9); // convert while selected
		u_host.transfer('1, 24, 1'b0, 1'b0); // config held high
		chk_lanes(12'hfff); // fresh results
		axi_read(8'h08, 32'hfff, '1, 2'h0); // widest range
		lvds_mode_in <= 1'b1;
		repeat (8) @(posedge aclk);
		axi_read(8'h04, 32'h4, 32'h4, 2'h0); // mode seen
		u_host.select();
		chk("oe_lvds", 7'h07, {lane_oe, lvds_oe, echo_oe, term_en}); // termination on
		u_host.transfer({84'h0, CFG1}, 96, 1'b1, 1'b0); // both edges
		chk("lvds", {word(0, smp[0], 3'h7), word(1, smp[1], 3'h7), word(2, smp[2], 3'h7),
			word(3, smp[3], 3'h7)}, u_host.lvds_cap); // channel order
		chk("echo_lvds", {24{4'h5}}, u_host.echo_cap); // clock copy
		axi_read(8'h08, {20'h0, CFG1}, '1, 2'h0); // word on both edges
		conclude();
	end
endmodule : quad_adc_serial_io_config_bench
